// ### inc/quick_stop_pkg.sv
// Constants, types and parameter map for the quick-stop controller.
// Assumes a single 50 MHz clock domain and a parameter port on the fieldbus.
package quick_stop_pkg;

   // Parameter addresses as seen over the fieldbus
   localparam logic [15:0] ADDR_RAMP_RATE = 16'h0624;
   localparam logic [15:0] ADDR_REACTION  = 16'h0630;
   localparam logic [15:0] ADDR_CURRENT   = 16'h111a;

   // Reset values and legal ranges
   localparam logic [31:0] RAMP_RESET     = 32'h0000_1770;
   localparam logic [31:0] RAMP_MIN       = 32'h0000_0001;
   localparam logic [31:0] RAMP_MAX       = 32'h7fff_ffff;
   localparam logic [15:0] REACT_DECEL    = 16'h0006;
   localparam logic [15:0] REACT_TORQUE   = 16'h0007;
   localparam logic [15:0] REACT_RESET    = REACT_DECEL;

   // Error classes that trigger a stop
   localparam logic [2:0]  ERR_CLASS_ONE  = 3'h1;
   localparam logic [2:0]  ERR_CLASS_TWO  = 3'h2;

   // Reported operating states
   localparam logic [3:0]  OPST_ENABLED   = 4'h6;
   localparam logic [3:0]  OPST_QSTOP     = 4'h7;
   localparam logic [3:0]  OPST_FAULT     = 4'h9;

   // Operating modes, codes arbitrary
   localparam logic [2:0]  MODE_PROF_TORQUE = 3'h1;
   localparam logic [2:0]  MODE_PROF_VEL    = 3'h2;

   typedef enum logic [1:0] {
      ST_RUN    = 2'b00,
      ST_DECEL  = 2'b01,
      ST_QSTOP  = 2'b10,
      ST_FAULT  = 2'b11
   } stop_state_e;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } param_req_s;

   typedef struct packed {
      logic [15:0] motor_max;
      logic [15:0] power_stage_max;
      logic [15:0] i2t_max;
   } current_caps_s;

endpackage

// ### core/quick_stop_control.sv
// Quick-stop sequencer, braking selection, current limit and analog inversion.
// Assumes all inputs synchronous to clk_i; parameter port driven by fieldbus.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Start a stop on class 1 or 2 error, or fieldbus stop command.
// - Reaction 6 brakes on ramp, 7 on torque; both report state 7 while braking.
// - After braking, enter configured state: fault 9 or quick-stop 7.
// - Reaction writes refused during braking; accepted writes act at once.
// - Ramp rate governs all stops; range 1 to 2147483647, reset 6000.
// - New ramp rate only takes effect at the next motor movement.
// - Stop current limit is least of setting, motor and stage maxima.
// - Thermal overload limit still applies throughout a stop.
// - Stored current setting is not clamped to motor or stage ratings.
// - Current setting is in 0.01 A rms steps and acts at once.
// - Default current setting is stage peak current at 8 kHz PWM.
// - Asserted inversion input inverts its own analog input evaluation.
// - Inversion only honoured in profile torque and profile velocity.
module quick_stop_control
   import quick_stop_pkg::*;
(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          sys_rst_i,
   // Parameter port
   input  wire param_req_s    param_i,
   output logic [31:0]        param_rdata_o,
   output logic               param_reject_o,
   // Stop triggers and sequencing
   input  wire logic          err_valid_i,
   input  wire logic [2:0]    err_class_i,
   input  wire logic          stop_cmd_i,
   input  wire logic          stop_release_i,
   input  wire logic          fault_after_stop_i,
   input  wire logic          motion_start_i,
   input  wire logic signed [31:0] velocity_i,
   // Current sources
   input  wire current_caps_s caps_i,
   input  wire logic [15:0]   power_stage_peak_current_i,
   // Analog inversion
   input  wire logic [2:0]    op_mode_i,
   input  wire logic          invert_analog_first_i,
   input  wire logic          invert_analog_second_i,
   // Status and controls
   output logic [3:0]         op_state_o,
   output logic               decel_active_o,
   output logic               use_torque_ramp_o,
   output logic [31:0]        stop_decel_ramp_o,
   output logic [15:0]        current_limit_o,
   output logic               analog_first_inv_o,
   output logic               analog_second_inv_o
);

   function automatic logic [15:0] min16(input logic [15:0] a,
                                          input logic [15:0] b);
      min16 = (a < b) ? a : b;
   endfunction

   stop_state_e state;
   stop_state_e next_state;
   logic [31:0] ramp_rate;
   logic [31:0] active_ramp;
   logic [15:0] stop_reaction_code;
   logic [15:0] stop_current_setting;

   // Decode
   wire sel_ramp    = param_i.addr == ADDR_RAMP_RATE;
   wire sel_react   = param_i.addr == ADDR_REACTION;
   wire sel_current = param_i.addr == ADDR_CURRENT;
   wire ramp_ok     = param_i.wdata >= RAMP_MIN && param_i.wdata <= RAMP_MAX;
   wire react_ok    = param_i.wdata[15:0] == REACT_DECEL ||
                      param_i.wdata[15:0] == REACT_TORQUE;
   wire braking     = state == ST_DECEL;
   wire wr_ramp     = param_i.wr && sel_ramp && ramp_ok;
   wire wr_react    = param_i.wr && sel_react && react_ok && !braking;
   wire wr_current  = param_i.wr && sel_current;
   wire wr_refused  = param_i.wr && !(wr_ramp || wr_react || wr_current);

   wire err_trigger = err_valid_i &&
                      (err_class_i == ERR_CLASS_ONE ||
                       err_class_i == ERR_CLASS_TWO);
   wire stop_trigger = err_trigger || stop_cmd_i;
   wire standstill   = velocity_i == 32'sh0000_0000;

   // Limit chain: thermal cap applies in every state
   wire [15:0] base_limit = min16(min16(caps_i.motor_max,
                                        caps_i.power_stage_max),
                                  caps_i.i2t_max);
   wire [15:0] stop_limit = min16(base_limit, stop_current_setting);

   wire inv_mode = op_mode_i == MODE_PROF_TORQUE ||
                   op_mode_i == MODE_PROF_VEL;

   always_comb begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (stop_trigger) begin
               next_state = ST_DECEL;
            end
         end
         ST_DECEL: begin
            if (standstill) begin
               next_state = fault_after_stop_i ? ST_FAULT : ST_QSTOP;
            end
         end
         ST_QSTOP, ST_FAULT: begin
            if (stop_release_i) begin
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_RUN;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ramp_rate            <= RAMP_RESET;
         active_ramp          <= RAMP_RESET;
         stop_reaction_code   <= REACT_RESET;
         // Sync reset, so sampling the rating port here is safe
         stop_current_setting <= power_stage_peak_current_i;
      end else begin
         if (wr_ramp) begin
            ramp_rate <= param_i.wdata;
         end
         // Latched only as a movement starts, never mid-stop
         if (motion_start_i && state == ST_RUN) begin
            active_ramp <= ramp_rate;
         end
         if (wr_react) begin
            stop_reaction_code <= param_i.wdata[15:0];
         end
         if (wr_current) begin
            stop_current_setting <= param_i.wdata[15:0];
         end
      end
   end

   wire [31:0] rd_mux = sel_ramp    ? ramp_rate :
                        sel_react   ? {16'h0000, stop_reaction_code} :
                        sel_current ? {16'h0000, stop_current_setting} :
                        32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         param_rdata_o  <= 32'h0000_0000;
         param_reject_o <= 1'b0;
      end else begin
         param_reject_o <= wr_refused;
         if (param_i.rd) begin
            param_rdata_o <= rd_mux;
         end
      end
   end

   wire [3:0] state_code = (state == ST_FAULT) ? OPST_FAULT :
                           (state == ST_RUN)   ? OPST_ENABLED : OPST_QSTOP;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         op_state_o          <= OPST_ENABLED;
         current_limit_o     <= 16'h0000;
         analog_first_inv_o  <= 1'b0;
         analog_second_inv_o <= 1'b0;
      end else begin
         op_state_o          <= state_code;
         current_limit_o     <= (state == ST_RUN) ? base_limit
                                                  : stop_limit;
         analog_first_inv_o  <= inv_mode && invert_analog_first_i;
         analog_second_inv_o <= inv_mode && invert_analog_second_i;
      end
   end

   assign decel_active_o    = braking;
   assign use_torque_ramp_o = stop_reaction_code == REACT_TORQUE;
   assign stop_decel_ramp_o = active_ramp;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   stop_start_a: assert property (
      state == ST_RUN && stop_trigger |=> state == ST_DECEL)
      else $error("stop trigger did not start braking");
   react_lock_a: assert property (
      braking && param_i.wr && sel_react |=> $stable(stop_reaction_code))
      else $error("reaction code changed during braking");
   react_reject_a: assert property (
      braking && param_i.wr && sel_react |=> param_reject_o)
      else $error("reaction write during braking not flagged");
   ramp_hold_a: assert property (
      !motion_start_i |=> $stable(stop_decel_ramp_o))
      else $error("active ramp changed without a new movement");
   end_state_a: assert property (
      braking && standstill && fault_after_stop_i
      |=> ##1 op_state_o == OPST_FAULT)
      else $error("fault state not reached after braking");
   qstop_state_a: assert property (
      braking && standstill && !fault_after_stop_i
      |=> ##1 op_state_o == OPST_QSTOP)
      else $error("quick-stop state not reached after braking");
   decel_wait_a: assert property (
      braking && !standstill |=> braking)
      else $error("braking ended while still moving");
   stop_limit_a: assert property (
      state == ST_DECEL |=> current_limit_o <= $past(stop_current_setting)
      && current_limit_o <= $past(caps_i.i2t_max))
      else $error("stop current limit above a cap");
   inv_mode_a: assert property (
      !inv_mode |=> !analog_first_inv_o && !analog_second_inv_o)
      else $error("inversion honoured outside profile modes");
   ramp_range_a: assert property (
      param_i.wr && sel_ramp && param_i.wdata == 32'h0000_0000
      |=> param_reject_o && $stable(ramp_rate))
      else $error("zero ramp rate accepted");

   stop_full_c: cover property (
      state == ST_RUN ##1 braking [*3] ##1 op_state_o == OPST_QSTOP);
   fault_path_c: cover property (braking ##1 state == ST_FAULT);
   torque_stop_c: cover property (use_torque_ramp_o && braking);
   inv_on_c: cover property (analog_first_inv_o && analog_second_inv_o);

endmodule

`default_nettype wire

// ### dv/motor_model.sv
// Motor model: measured velocity behind the power stage.
// Assumes a start pulse from the bench and braking status from the block.
`timescale 1ns/100ps
`default_nettype none
module motor_model #(
   parameter int SPEED = 40,
   parameter int STEP  = 4
) (
   input  wire logic               clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic               motion_start_i,
   input  wire logic               decel_active_i,
   output logic signed [31:0]      velocity_o
);
   // Ten cycles of braking leave room to poke the port mid-stop
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         velocity_o <= '0;
      else if (motion_start_i)
         velocity_o <= SPEED;
      else if (decel_active_i && velocity_o != 0)
         velocity_o <= velocity_o - STEP;
   end
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the quick-stop controller.
// Assumes the motor model supplies velocity; reads are scored from a queue.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import quick_stop_pkg::*;
   logic               clk_i = 0;
   logic               sys_rst_i = 1;
   param_req_s         prm;
   current_caps_s      caps;
   logic [31:0]        rdata, ramp_o, expq[$];
   logic [15:0]        peak, ilim, cur, run_lim;
   logic [3:0]         op_state;
   logic [2:0]         err_cls, mode;
   logic               reject, err_v, stop_cmd, rel, flt, start, inv1, inv2;
   logic               decel, torque, ainv1, ainv2, rd_d;
   logic signed [31:0] vel;
   int                 miscompares = 0, n_checks = 0, cycles = 0, n;

   always #10 clk_i = ~clk_i;

   function automatic logic [15:0] mn(logic [15:0] a, logic [15:0] b);
      return (a < b) ? a : b;
   endfunction
   assign run_lim = mn(mn(caps.motor_max, caps.power_stage_max), caps.i2t_max);

   quick_stop_control uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .param_i(prm), .param_rdata_o(rdata), .param_reject_o(reject),
      .err_valid_i(err_v), .err_class_i(err_cls), .stop_cmd_i(stop_cmd),
      .stop_release_i(rel), .fault_after_stop_i(flt),
      .motion_start_i(start), .velocity_i(vel), .caps_i(caps),
      .power_stage_peak_current_i(peak), .op_mode_i(mode),
      .invert_analog_first_i(inv1), .invert_analog_second_i(inv2),
      .op_state_o(op_state), .decel_active_o(decel),
      .use_torque_ramp_o(torque), .stop_decel_ramp_o(ramp_o),
      .current_limit_o(ilim), .analog_first_inv_o(ainv1),
      .analog_second_inv_o(ainv2));
   motor_model motor (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .motion_start_i(start), .decel_active_i(decel), .velocity_o(vel));

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] seen);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [31:0] d, logic rej);
      @(negedge clk_i);
      prm = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk_i);
      prm.wr = 1'b0;
      chk("reject", rej, reject);
   endtask
   // Expected data queued here, scored by the monitor below
   task automatic rd(logic [15:0] a, logic [31:0] exp);
      @(negedge clk_i);
      prm = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      expq.push_back(exp);
      @(negedge clk_i);
      prm.rd = 1'b0;
   endtask
   always @(posedge clk_i) rd_d <= prm.rd;
   always @(negedge clk_i)
      if (rd_d) chk("rdata", expq.pop_front(), rdata);

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         wrap_up();
      end
   end

   initial begin
      prm = '0; err_v = 0; err_cls = '0; stop_cmd = 0; rel = 0; flt = 0;
      start = 0; mode = '0; inv1 = 0; inv2 = 0;
      n = $urandom(35);
      peak = 16'($urandom);
      caps = {16'($urandom), 16'($urandom), 16'($urandom)};
      repeat (10) @(negedge clk_i);
      sys_rst_i = 0;
      rd(ADDR_RAMP_RATE, RAMP_RESET);
      rd(ADDR_REACTION, {16'h0, REACT_RESET});
      rd(ADDR_CURRENT, {16'h0, peak});
      rd(16'h0700, 32'h0);
      chk("ramp_out", RAMP_RESET, ramp_o);
      wr(ADDR_RAMP_RATE, 32'h0, 1);
      wr(ADDR_RAMP_RATE, 32'h8000_0000, 1);
      wr(ADDR_RAMP_RATE, RAMP_MAX, 0);
      wr(16'h0700, 32'h1, 1);
      wr(ADDR_REACTION, 32'h5, 1);
      rd(ADDR_RAMP_RATE, RAMP_MAX);
      chk("ramp_out", RAMP_RESET, ramp_o);
      for (int k = 0; k < 4; k++) begin
         cur = 16'($urandom);
         caps = {16'($urandom), 16'($urandom), 16'($urandom)};
         wr(ADDR_CURRENT, {16'h0, cur}, 0);
         rd(ADDR_CURRENT, {16'h0, cur});
         wr(ADDR_REACTION, k[0] ? REACT_TORQUE : REACT_DECEL, 0);
         chk("torque", k[0], torque);
         flt = k[1];
         @(negedge clk_i) start = 1;
         @(negedge clk_i) start = 0;
         stop_cmd = (k == 0);
         err_v = (k != 0);
         err_cls = 3'(k);
         @(negedge clk_i) chk("decel", k != 3, decel);
         stop_cmd = 0;
         err_v = 0;
         if (k == 0) chk("ramp_out", RAMP_MAX, ramp_o);
         if (k != 3) begin
            @(negedge clk_i) chk("state", OPST_QSTOP, op_state);
            chk("ilim", mn(cur, run_lim), ilim);
            wr(ADDR_REACTION, REACT_DECEL, 1);
            n = 0;
            while (decel === 1'b1 && n < 100) begin
               @(negedge clk_i);
               n++;
            end
            chk("velocity", 32'h0, vel);
            @(negedge clk_i) chk("state", flt ? OPST_FAULT : OPST_QSTOP,
               op_state);
            @(negedge clk_i) rel = 1;
            @(negedge clk_i) rel = 0;
         end
         repeat (2) @(negedge clk_i);
         chk("state", OPST_ENABLED, op_state);
         chk("ilim", run_lim, ilim);
      end
      // Every mode code, so the two honoured modes stand out
      for (int k = 0; k < 8; k++) begin
         @(negedge clk_i) mode = 3'(k);
         inv1 = 1'($urandom);
         inv2 = 1'($urandom);
         @(negedge clk_i);
         chk("inv1", inv1 & (k == 1 || k == 2), ainv1);
         chk("inv2", inv2 & (k == 1 || k == 2), ainv2);
      end
      repeat (2) @(negedge clk_i);
      wrap_up();
   end
endmodule
`default_nettype wire
